// ==== verilog/rfp_top.sv ====
// Fault supervisor for the secondary output rail
// Functional notes
// - Above the 0.9V target, sense over reference plus 325mV is over-voltage.
// - Below the 0.9V target, sense over a fixed 0.9V plus 325mV is over-voltage.
// - While over-voltage is latched, all active phases run low side on, high side off.
// - A latched over-voltage asks the sibling rail to soft shut down.
// - Over-voltage must persist 1 us before the latch sets.
// - Latched over-voltage with sense below 0V turns all low sides off, high sides off.
// - Once sense rises above 0V again, low sides turn back on under the over-voltage latch.
// - The negative check is ignored unless over-voltage is latched.
// - Sense below reference by 500mV sets the under-voltage latch.
// - While under-voltage is latched, both switches of every phase are off.
// - A latched under-voltage asks the sibling rail to soft shut down.
// - Under-voltage must persist 3 us before the latch sets.
// - A supply comparator report below the power-on threshold triggers lockout.
// - Lockout stops modulation and forces every switch control off.
// - Supply low must persist 3 us before lockout.
// Sense and reference share a 1 mV step; the target code steps in 10 mV.
// A target exactly at 0.9V takes the fixed over-voltage level.
// Lockout follows the supply: it lets go once the qualified low report clears,
// but it never clears the fault latches, which wait for reset or a fresh enable.
// The sense-below-zero and supply comparators arrive unsynchronised and pass
// two flip-flops first, so their response trails the pin by two extra edges.
`include "rfp_defs.svh"
module rfp_top
	import rfp_pkg::*;
#(
	parameter int PHASES = 2,
	parameter int SW     = `RFP_SENSE_W
)
(
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic              enable,
	input  wire logic [`RFP_TGT_W-1:0] voltage_target_code,
	input  wire logic [SW-1:0]     rail_output_sense,
	input  wire logic [SW-1:0]     reference_level,
	input  wire logic              sense_below_zero,
	input  wire logic              supply_below_por,
	input  wire logic [PHASES-1:0] phase_active,
	input  wire logic [PHASES-1:0] pwm_high_req,
	input  wire logic [PHASES-1:0] pwm_low_req,
	output logic [PHASES-1:0]      high_side_on,
	output logic [PHASES-1:0]      low_side_on,
	output logic                   modulation_run,
	output logic                   sibling_shutdown,
	output logic                   overvoltage_fault,
	output logic                   negative_voltage_fault,
	output logic                   undervoltage_fault,
	output logic                   supply_lockout
);
	typedef struct packed
	{
		logic [1:0]        nz_sync;
		logic [1:0]        por_sync;
		logic              en_d;
		rfp_mode_t         mode;
		logic              lock;
		logic              sib;
		logic [PHASES-1:0] hs;
		logic [PHASES-1:0] ls;
		logic              run;
		logic              ovf;
		logic              nvf;
		logic              uvf;
	} rfp_st_t;
	rfp_st_t st_reg;
	rfp_st_t st_next;

	rfp_qual_if ov_q ();
	rfp_qual_if uv_q ();
	rfp_qual_if lo_q ();

	logic [SW:0]   ov_limit;
	logic [SW:0]   uv_limit;
	logic          fresh_en;

	// Threshold choice: fixed level for low targets, tracking level otherwise
	always_comb
	begin
		if (voltage_target_code > `RFP_TGT_0V9)
			ov_limit = {1'b0, reference_level} + {1'b0, `RFP_OV_MARGIN};
		else
			ov_limit = {1'b0, `RFP_FIXED_OV_LVL};
		uv_limit = {1'b0, reference_level} - {1'b0, `RFP_UV_MARGIN};
	end

	// A rising enable starts a new run and wipes the fault latches
	assign fresh_en = enable && !st_reg.en_d;

	// Raw comparisons feed the persistence filters
	assign ov_q.raw = enable && ({1'b0, rail_output_sense} > ov_limit);
	// Reference under 500mV makes uv_limit negative; treat as never under
	assign uv_q.raw = enable && !uv_limit[SW] && ({1'b0, rail_output_sense} < uv_limit);
	assign lo_q.raw = st_reg.por_sync[1];
	assign ov_q.clr = fresh_en;
	assign uv_q.clr = fresh_en;
	assign lo_q.clr = 1'b0;

	rfp_qual #(.CYCLES(`RFP_OV_CYC)) u_ov_qual
	(
		.clock (clock),
		.rst_b (rst_b),
		.q     (ov_q)
	);
	rfp_qual #(.CYCLES(`RFP_UV_CYC)) u_uv_qual
	(
		.clock (clock),
		.rst_b (rst_b),
		.q     (uv_q)
	);
	rfp_qual #(.CYCLES(`RFP_LO_CYC)) u_lo_qual
	(
		.clock (clock),
		.rst_b (rst_b),
		.q     (lo_q)
	);

	// Fault sequencing and gate override; lockout outranks every latch
	always_comb
	begin
		st_next = st_reg;
		st_next.nz_sync = {st_reg.nz_sync[0], sense_below_zero};
		st_next.por_sync = {st_reg.por_sync[0], supply_below_por};
		st_next.en_d = enable;
		// Lockout follows the qualified supply state; it releases when the supply is back
		if (lo_q.hit)
			st_next.lock = 1'b1;
		else if (!st_reg.por_sync[1])
			st_next.lock = 1'b0;
		if (fresh_en)
		begin
			st_next.mode = RFP_RUN;
			st_next.sib = 1'b0;
		end
		else
		begin
			case (st_reg.mode)
				RFP_RUN:
				begin
					if (ov_q.hit)
					begin
						st_next.mode = RFP_OVP;
						st_next.sib = 1'b1;
					end
					else if (uv_q.hit)
					begin
						st_next.mode = RFP_UVP;
						st_next.sib = 1'b1;
					end
				end
				RFP_OVP:
				begin
					// Negative check exists only inside the over-voltage latch
					if (st_reg.nz_sync[1])
						st_next.mode = RFP_NVP;
				end
				RFP_NVP:
				begin
					if (!st_reg.nz_sync[1])
						st_next.mode = RFP_OVP;
				end
				RFP_UVP:
				begin
					st_next.mode = RFP_UVP;
				end
				default:
				begin
					st_next.mode = RFP_RUN;
				end
			endcase
		end
		// Fault flags registered with the mode so each output leaves a flip-flop
		st_next.ovf = (st_next.mode == RFP_OVP) || (st_next.mode == RFP_NVP);
		st_next.nvf = (st_next.mode == RFP_NVP);
		st_next.uvf = (st_next.mode == RFP_UVP);
		// Gate drive decision uses next mode so the override lands with the latch
		st_next.run = enable && !st_next.lock;
		if (st_next.lock || !enable)
		begin
			st_next.hs = '0;
			st_next.ls = '0;
		end
		else
		begin
			case (st_next.mode)
				RFP_OVP:
				begin
					st_next.hs = '0;
					st_next.ls = phase_active;
				end
				RFP_NVP:
				begin
					st_next.hs = '0;
					st_next.ls = '0;
				end
				RFP_UVP:
				begin
					st_next.hs = '0;
					st_next.ls = '0;
				end
				default:
				begin
					st_next.hs = pwm_high_req & phase_active;
					st_next.ls = pwm_low_req & phase_active & ~pwm_high_req;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			st_reg <= '{nz_sync: 2'h0, por_sync: 2'h0, en_d: 1'b0, mode: RFP_RUN,
				lock: 1'b0, sib: 1'b0, hs: '0, ls: '0, run: 1'b0,
				ovf: 1'b0, nvf: 1'b0, uvf: 1'b0};
		else
			st_reg <= st_next;
	end

	// Outputs straight from state flip-flops
	assign high_side_on = st_reg.hs;
	assign low_side_on = st_reg.ls;
	assign modulation_run = st_reg.run;
	assign sibling_shutdown = st_reg.sib;
	assign overvoltage_fault = st_reg.ovf;
	assign negative_voltage_fault = st_reg.nvf;
	assign undervoltage_fault = st_reg.uvf;
	assign supply_lockout = st_reg.lock;

	// Raw compares restated in integer arithmetic, apart from the 13-bit limits
	a_ov_raw_trk: assert property (@(posedge clock) disable iff (!rst_b)
		enable && (voltage_target_code > `RFP_TGT_0V9) |-> ov_q.raw ==
		(int'(rail_output_sense) > int'(reference_level) + int'(`RFP_OV_MARGIN)))
		else $error("tracking over-voltage compare wrong");
	a_ov_raw_fix: assert property (@(posedge clock) disable iff (!rst_b)
		enable && (voltage_target_code <= `RFP_TGT_0V9) |->
		ov_q.raw == (int'(rail_output_sense) > int'(`RFP_FIXED_OV_LVL)))
		else $error("fixed over-voltage compare wrong");
	a_uv_raw_lvl: assert property (@(posedge clock) disable iff (!rst_b)
		enable |-> uv_q.raw ==
		(int'(rail_output_sense) < int'(reference_level) - int'(`RFP_UV_MARGIN)))
		else $error("under-voltage compare wrong");

	// Over-voltage drive: high sides off, low sides follow the active mask
	a_ov_gate_low: assert property (@(posedge clock) disable iff (!rst_b)
		(st_reg.mode == RFP_OVP) && !st_reg.lock && enable |-> st_reg.hs == '0)
		else $error("high side on during over-voltage");
	a_ov_low_on: assert property (@(posedge clock) disable iff (!rst_b)
		overvoltage_fault && !negative_voltage_fault && !supply_lockout && $past(enable)
		|-> low_side_on == $past(phase_active) && high_side_on == '0)
		else $error("low sides not on during over-voltage");
	a_ov_sibling: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(overvoltage_fault) |-> sibling_shutdown)
		else $error("sibling not told on over-voltage");
	a_sib_hold: assert property (@(posedge clock) disable iff (!rst_b)
		sibling_shutdown && !fresh_en |=> sibling_shutdown)
		else $error("sibling request dropped");
	a_ov_entry: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(overvoltage_fault) |-> $past(ov_q.hit))
		else $error("over-voltage latched without qualification");

	// Negative protection lives only inside the over-voltage latch
	a_nv_all_off: assert property (@(posedge clock) disable iff (!rst_b)
		negative_voltage_fault |-> (high_side_on == '0) && (low_side_on == '0))
		else $error("switch on during negative protection");
	a_nv_release: assert property (@(posedge clock) disable iff (!rst_b)
		negative_voltage_fault && !st_reg.nz_sync[1] && !fresh_en
		|=> overvoltage_fault && !negative_voltage_fault)
		else $error("negative protection not released");
	a_nv_only_ov: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(negative_voltage_fault) |-> $past(st_reg.mode) == RFP_OVP)
		else $error("negative protection outside over-voltage");
	a_nv_ignored: assert property (@(posedge clock) disable iff (!rst_b)
		!overvoltage_fault |=> !negative_voltage_fault)
		else $error("negative protection without over-voltage");

	// Under-voltage: everything off, sibling told, entry only after the filter
	a_uv_all_off: assert property (@(posedge clock) disable iff (!rst_b)
		undervoltage_fault |-> (high_side_on == '0) && (low_side_on == '0))
		else $error("switch on during under-voltage");
	a_uv_sibling: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(undervoltage_fault) |-> sibling_shutdown)
		else $error("sibling not told on under-voltage");
	a_uv_entry: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(undervoltage_fault) |-> $past(uv_q.hit))
		else $error("under-voltage latched without qualification");

	// Lockout stops modulation and every gate; run follows enable otherwise
	a_lock_off: assert property (@(posedge clock) disable iff (!rst_b)
		supply_lockout |-> !modulation_run && high_side_on == '0 && low_side_on == '0)
		else $error("drive active during lockout");
	a_run_follows: assert property (@(posedge clock) disable iff (!rst_b)
		!supply_lockout && $past(rst_b) |-> modulation_run == $past(enable))
		else $error("modulation state does not follow enable");
	a_lock_entry: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(supply_lockout) |-> $past(lo_q.hit))
		else $error("lockout without qualification");

	// Latches hold until a fresh enable
	a_latch_hold: assert property (@(posedge clock) disable iff (!rst_b)
		undervoltage_fault && !fresh_en |=> undervoltage_fault)
		else $error("under-voltage latch dropped");
	a_ov_hold: assert property (@(posedge clock) disable iff (!rst_b)
		overvoltage_fault && !fresh_en |=> overvoltage_fault)
		else $error("over-voltage latch dropped");
endmodule

// ==== verilog/rfp_defs.svh ====
// Constants for the rail fault protection logic
`ifndef RFP_DEFS_SVH
`define RFP_DEFS_SVH
`define RFP_CLK_MHZ      40
`define RFP_OV_DLY_NS    1000
`define RFP_UV_DLY_NS    3000
`define RFP_LO_DLY_NS    3000
`define RFP_OV_CYC       ((`RFP_OV_DLY_NS * `RFP_CLK_MHZ + 999) / 1000)
`define RFP_UV_CYC       ((`RFP_UV_DLY_NS * `RFP_CLK_MHZ + 999) / 1000)
`define RFP_LO_CYC       ((`RFP_LO_DLY_NS * `RFP_CLK_MHZ + 999) / 1000)
`define RFP_CNT_W        8
`define RFP_TGT_W        8
`define RFP_TGT_0V9      8'h5a
`define RFP_SENSE_W      12
`define RFP_OV_MARGIN    12'h145
`define RFP_UV_MARGIN    12'h1f4
`define RFP_FIXED_OV_LVL 12'h4c9
`endif

// ==== verilog/rfp_pkg.sv ====
// Types for the rail fault protection logic
package rfp_pkg;
	typedef enum logic [1:0] {RFP_RUN, RFP_OVP, RFP_NVP, RFP_UVP} rfp_mode_t;
endpackage

// ==== verilog/rfp_qual_if.sv ====
// Carrier between the supervisor and one qualification filter
interface rfp_qual_if;
	logic raw;
	logic clr;
	logic hit;
	modport ctl (output raw, output clr, input hit);
	modport flt (input raw, input clr, output hit);
endinterface

// ==== verilog/rfp_qual.sv ====
// Persistence filter: counts cycles of a raw condition, resets on any drop
`include "rfp_defs.svh"
module rfp_qual
	import rfp_pkg::*;
#(
	parameter int CYCLES = 40
)
(
	input wire logic clock,
	input wire logic rst_b,
	rfp_qual_if.flt  q
);
	typedef struct packed
	{
		logic [`RFP_CNT_W-1:0] cnt;
		logic                  hit;
	} rfp_qst_t;
	rfp_qst_t st_reg;
	rfp_qst_t st_next;
	localparam logic [`RFP_CNT_W-1:0] TERM = `RFP_CNT_W'(CYCLES - 1);

	// Counter restarts whenever the raw input drops before terminal count
	always_comb
	begin
		st_next = st_reg;
		st_next.hit = 1'b0;
		if (q.clr || !q.raw)
			st_next.cnt = '0;
		else if (st_reg.cnt == TERM)
			st_next.hit = 1'b1;
		else
			st_next.cnt = st_reg.cnt + 8'h01;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign q.hit = st_reg.hit;

	// Hit only after the raw level stood for the full count
	a_qual_persist: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(st_reg.hit) |-> $past(q.raw) && $past(st_reg.cnt) == TERM)
		else $error("qualifier fired without full persistence");
endmodule

// ==== tb/rfp_stage_model.sv ====
// Model of the gate driver stage and the sibling rail controller
module rfp_stage_model
#(
	parameter int PHASES = 2
)
(
	input  wire logic              clock,
	input  wire logic [PHASES-1:0] high_side_on,
	input  wire logic [PHASES-1:0] low_side_on,
	input  wire logic              sibling_shutdown,
	output int                     shoot_cnt,
	output logic                   sibling_off
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		shoot_cnt = 0;
		sibling_off = 1'b0;
	end
	// Both switches of one leg on would short the input; a soft stop never undoes itself
	always @(posedge clock)
	begin
		if (|(high_side_on & low_side_on))
			shoot_cnt <= shoot_cnt + 1;
		if (sibling_shutdown)
			sibling_off <= 1'b1;
	end
endmodule

// ==== tb/rail_fault_protection_logic_tb.sv ====
// Self-checking bench for the rail fault supervisor
module rail_fault_protection_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0, rst_b = 1'b0, enable = 1'b0;
	logic [7:0]  voltage_target_code = 8'h64;
	logic [11:0] rail_output_sense = 12'h3e8, reference_level = 12'h3e8;
	logic        sense_below_zero = 1'b0, supply_below_por = 1'b0;
	logic [1:0]  phase_active = 2'h3, pwm_high_req = 2'h0, pwm_low_req = 2'h0;
	logic [1:0]  high_side_on, low_side_on;
	logic        modulation_run, sibling_shutdown, overvoltage_fault;
	logic        negative_voltage_fault, undervoltage_fault, supply_lockout, sibling_off;
	int          shoot_cnt, miscompares = 0, comparisons = 0, n, seed;
	// Latencies worked out from the filter times at 40 MHz, plus the latch edge
	int          ov_lat = 1000 * 40 / 1000 + 1, uv_lat = 3000 * 40 / 1000 + 1;
	always #12.5 clock = ~clock;
	rfp_top dut (.clock(clock), .rst_b(rst_b), .enable(enable),
		.voltage_target_code(voltage_target_code), .rail_output_sense(rail_output_sense),
		.reference_level(reference_level), .sense_below_zero(sense_below_zero),
		.supply_below_por(supply_below_por), .phase_active(phase_active),
		.pwm_high_req(pwm_high_req), .pwm_low_req(pwm_low_req), .high_side_on(high_side_on),
		.low_side_on(low_side_on), .modulation_run(modulation_run),
		.sibling_shutdown(sibling_shutdown), .overvoltage_fault(overvoltage_fault),
		.negative_voltage_fault(negative_voltage_fault),
		.undervoltage_fault(undervoltage_fault), .supply_lockout(supply_lockout));
	rfp_stage_model stage (.clock(clock), .high_side_on(high_side_on),
		.low_side_on(low_side_on), .sibling_shutdown(sibling_shutdown),
		.shoot_cnt(shoot_cnt), .sibling_off(sibling_off));
	task automatic report_and_stop();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	function automatic logic flag(input int s);
		case (s)
			0: return overvoltage_fault;
			1: return undervoltage_fault;
			2: return supply_lockout;
			default: return negative_voltage_fault;
		endcase
	endfunction
	// Count falling edges until a flag reaches a level; a hang ends the run
	task automatic wait_for(input int s, input logic lvl, output int cnt);
		for (cnt = 1; cnt <= 400; cnt++)
		begin
			@(negedge clock);
			if (flag(s) === lvl)
				return;
		end
		miscompares++;
		$display("MISMATCH wait flag %0d expected %0h seen timeout", s, lvl);
		report_and_stop();
	endtask
	task automatic hold(input int cyc);
		repeat (cyc) @(negedge clock);
	endtask
	// Drop enable for one cycle so the latches clear, then let filters settle
	task automatic fresh_enable();
		enable = 1'b0;
		hold(1);
		enable = 1'b1;
		hold(4);
	endtask
	initial
	begin
		seed = $urandom(32'hb0e76e23);
		repeat (10) @(posedge clock);
		@(negedge clock) rst_b = 1'b1;
		chk("flags after reset", 0, {overvoltage_fault, undervoltage_fault, supply_lockout});
		enable = 1'b1;
		// Normal drive: random requests, low side held off while high side asked for
		repeat (8)
		begin
			phase_active = 2'($urandom_range(1, 3));
			pwm_high_req = 2'($urandom);
			pwm_low_req = 2'($urandom);
			hold(2);
			chk("high normal", phase_active & pwm_high_req, high_side_on);
			chk("low normal", phase_active & pwm_low_req & ~pwm_high_req, low_side_on);
			chk("run", 1, modulation_run);
		end
		pwm_high_req = 2'h1;
		pwm_low_req = 2'h2;
		sense_below_zero = 1'b1;
		hold(8);
		chk("nv ignored", 0, negative_voltage_fault);
		sense_below_zero = 1'b0;
		rail_output_sense = 12'h3e8 + 12'd325;
		hold(60);
		rail_output_sense = 12'h3e8 + 12'd300;
		hold(60);
		chk("ov at margin and over fixed", 0, overvoltage_fault);
		rail_output_sense = 12'h3e8 + 12'd326;
		hold(ov_lat - 2);
		rail_output_sense = 12'h3e8;
		hold(50);
		chk("ov short", 0, overvoltage_fault);
		rail_output_sense = 12'h3e8 + 12'd326;
		wait_for(0, 1'b1, n);
		chk("ov latency", ov_lat, n);
		chk("ov gates", {2'h0, phase_active}, {high_side_on, low_side_on});
		chk("ov sibling", 1, sibling_shutdown);
		sense_below_zero = 1'b1;
		wait_for(3, 1'b1, n);
		chk("nv latency", 3, n);
		chk("nv gates", 0, {high_side_on, low_side_on});
		// The sibling samples the request one edge after it is raised
		chk("sibling stopped", 1, sibling_off);
		sense_below_zero = 1'b0;
		wait_for(3, 1'b0, n);
		chk("nv release", 3, n);
		chk("nv release low", phase_active, low_side_on);
		rail_output_sense = 12'h3e8 - 12'd501;
		hold(uv_lat + 10);
		chk("ov kept", 2'h2, {overvoltage_fault, undervoltage_fault});
		rail_output_sense = 12'h3e8;
		fresh_enable();
		chk("ov cleared", 0, {overvoltage_fault, sibling_shutdown});
		voltage_target_code = 8'h5a;
		rail_output_sense = 12'd1225;
		hold(60);
		chk("fixed margin", 0, overvoltage_fault);
		rail_output_sense = 12'd1226;
		wait_for(0, 1'b1, n);
		chk("fixed latency", ov_lat, n);
		rail_output_sense = 12'h3e8;
		fresh_enable();
		rail_output_sense = 12'h3e8 - 12'd500;
		hold(150);
		rail_output_sense = 12'h3e8 - 12'd501;
		hold(uv_lat - 2);
		rail_output_sense = 12'h3e8;
		hold(10);
		chk("uv short", 0, undervoltage_fault);
		rail_output_sense = 12'h3e8 - 12'd501;
		wait_for(1, 1'b1, n);
		chk("uv latency", uv_lat, n);
		chk("uv gates", 0, {high_side_on, low_side_on});
		chk("uv sibling", 1, sibling_shutdown);
		rail_output_sense = 12'h3e8;
		fresh_enable();
		supply_below_por = 1'b1;
		hold(100);
		supply_below_por = 1'b0;
		hold(10);
		chk("lockout short", 0, supply_lockout);
		supply_below_por = 1'b1;
		wait_for(2, 1'b1, n);
		// Two synchroniser edges ahead of the 3 us filter and the latch edge
		chk("lockout latency", uv_lat + 2, n);
		chk("lockout gates", 0, {high_side_on, low_side_on, modulation_run});
		supply_below_por = 1'b0;
		wait_for(2, 1'b0, n);
		// Two synchroniser edges, the filter drop, then the lockout edge
		chk("lockout release", 4, n);
		hold(2);
		chk("run again", 1, modulation_run);
		chk("shoot through", 0, shoot_cnt);
		report_and_stop();
	end
endmodule
